// [rotate_return_sleep_pkg.sv]
// Function
// RQ1: Return pops stack top into program counter
// RQ2: Return takes two cycles, flags untouched
// RQ3: Rotate left through carry, only carry changes
// RQ4: Left rotate destination bit picks file or working
// RQ5: Rotate right through carry, only carry changes
// RQ6: Right rotate destination bit picks file or working
// RQ7: Sleep clears powerdown status flag
// RQ8: Sleep sets timeout flag, clears watchdog, prescaler
// RQ9: Sleep then halts oscillator, enters sleep state
// RQ10: Carry enters vacated bit, outgoing bit to carry
package rotate_return_sleep_pkg;
   // ==========================================================
   // Widths and opcodes
   localparam int RA_W   = 13;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int WDG_W  = 8;
   localparam int PRE_W  = 8;
   localparam int MSB    = DATA_W - 1;

   typedef enum logic [2:0] {
      OP_NONE      = 3'h0,
      OP_RETURN    = 3'h1,
      OP_ROT_LEFT  = 3'h2,
      OP_ROT_RIGHT = 3'h3,
      OP_SLEEP     = 3'h4
   } op_e;

   // ==========================================================
   // Reset and sleep values, destination encoding
   localparam logic [RA_W-1:0]  RA_RST  = 13'h0000;
   localparam logic [WDG_W-1:0] WDG_CLR = 8'h00;
   localparam logic [PRE_W-1:0] PRE_CLR = 8'h00;
   localparam logic             DEST_FILE = 1'b1;
   // Both status flags read 1 out of reset; sleep drives them apart
   localparam logic             TIMEOUT_RST     = 1'b1;
   localparam logic             POWERDOWN_RST   = 1'b1;
   localparam logic             TIMEOUT_SLEEP   = 1'b1;
   localparam logic             POWERDOWN_SLEEP = 1'b0;
   localparam logic             OSC_RST         = 1'b1;

   // ==========================================================
   // Rotate through carry: {carry_out, result}
   function automatic logic [DATA_W:0] rotate_carry(input logic [DATA_W-1:0] v,
                                                      input logic              c,
                                                      input logic              left);
      if (left) begin
         rotate_carry = {v[MSB], v[MSB-1:0], c};
      end else begin
         rotate_carry = {v[0], c, v[MSB:1]};
      end
   endfunction : rotate_carry
endpackage : rotate_return_sleep_pkg

// [rotate_unit.sv]
`timescale 1ns/1ps
module rotate_unit
   import rotate_return_sleep_pkg::*;
(
   input  wire logic [DATA_W-1:0] operand_i,
   input  wire logic              carry_i,
   input  wire logic              left_i,
   output logic      [DATA_W-1:0] result_o,
   output logic                   carry_o
);
   logic [DATA_W:0] r;
   always_comb begin
      r        = rotate_carry(operand_i, carry_i, left_i); // [RQ10]
      result_o = r[DATA_W-1:0];
      carry_o  = r[DATA_W];
   end
endmodule : rotate_unit

// [rotate_return_sleep_exec.sv]
`timescale 1ns/1ps
module rotate_return_sleep_exec
   import rotate_return_sleep_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              issue_i,
   input  wire op_e               op_i,
   input  wire logic [ADDR_W-1:0] file_addr_i,
   input  wire logic              dest_i,
   input  wire logic [DATA_W-1:0] file_data_i,
   input  wire logic              carry_i,
   input  wire logic [RA_W-1:0]   stack_top_entry_i,
   input  wire logic              wake_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic                   stack_pop_o,
   output logic                   pc_load_o,
   output logic      [RA_W-1:0]   program_counter_o,
   output logic                   file_we_o,
   output logic      [ADDR_W-1:0] file_waddr_o,
   output logic      [DATA_W-1:0] file_wdata_o,
   output logic                   w_we_o,
   output logic      [DATA_W-1:0] w_wdata_o,
   output logic                   carry_we_o,
   output logic                   carry_o,
   output logic                   timeout_status_flag_o,
   output logic                   powerdown_status_flag_o,
   output logic                   watchdog_clear_o,
   output logic      [WDG_W-1:0]  watchdog_counter_o,
   output logic      [PRE_W-1:0]  prescaler_o,
   output logic                   osc_run_o,
   output logic                   sleeping_o
);
   // ==========================================================
   // State
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RET2  = 2'b01,
      ST_SLEEP = 2'b10
   } state_e;

   typedef struct packed {
      state_e            st;
      logic              busy;
      logic              done;
      logic              pop;
      logic              pc_load;
      logic [RA_W-1:0]   ra;
      logic              f_we;
      logic [ADDR_W-1:0] f_addr;
      logic [DATA_W-1:0] f_data;
      logic              w_we;
      logic [DATA_W-1:0] w_data;
      logic              c_we;
      logic              c;
      logic              tout;
      logic              pdwn;
      logic              wdg_clr;
      logic [WDG_W-1:0]  wdg;
      logic [PRE_W-1:0]  pre;
      logic              osc;
      logic              sleep;
   } state_s;

   state_s s;
   state_s next_s;

   logic [DATA_W-1:0] rot_result;
   logic              rot_carry;

   // ==========================================================
   // Decode
   // Opcodes outside the four handled here leave the core idle
   function automatic logic op_is_legal(input op_e op);
      case (op)
         OP_RETURN,
         OP_ROT_LEFT,
         OP_ROT_RIGHT,
         OP_SLEEP: begin
            op_is_legal = 1'b1;
         end
         default: begin
            op_is_legal = 1'b0;
         end
      endcase
   endfunction : op_is_legal

   // ==========================================================
   // Rotate datapath
   // Operand comes straight from the file read port, so the result
   // is ready in the issue cycle and lands one edge later
   rotate_unit u_rot (
      .operand_i (file_data_i),
      .carry_i   (carry_i),
      .left_i    (op_i == OP_ROT_LEFT),
      .result_o  (rot_result),
      .carry_o   (rot_carry)
   );

   // ==========================================================
   // Next state
   // wake_i is an on-chip event on this clock; no synchroniser needed
   always_comb begin
      next_s         = s;
      next_s.done    = 1'b0;
      next_s.pop     = 1'b0;
      next_s.pc_load = 1'b0;
      next_s.f_we    = 1'b0;
      next_s.w_we    = 1'b0;
      next_s.c_we    = 1'b0;
      next_s.wdg_clr = 1'b0;
      case (s.st)
         ST_IDLE: begin
            if (issue_i && op_is_legal(op_i)) begin
               case (op_i)
                  OP_RETURN: begin
                     next_s.pop     = 1'b1;                    // [RQ1]
                     next_s.ra      = stack_top_entry_i;       // [RQ1]
                     next_s.busy    = 1'b1;
                     next_s.st      = ST_RET2;                 // [RQ2]
                  end
                  OP_ROT_LEFT, OP_ROT_RIGHT: begin
                     // Carry only; zero and digit carry are left alone
                     next_s.c_we = 1'b1;                       // [RQ3] [RQ5]
                     next_s.c    = rot_carry;                  // [RQ10]
                     next_s.done = 1'b1;
                     if (dest_i == DEST_FILE) begin
                        next_s.f_we   = 1'b1;                  // [RQ4] [RQ6]
                        next_s.f_addr = file_addr_i;
                        next_s.f_data = rot_result;
                     end else begin
                        next_s.w_we   = 1'b1;                  // [RQ4] [RQ6]
                        next_s.w_data = rot_result;
                     end
                  end
                  OP_SLEEP: begin
                     next_s.pdwn    = POWERDOWN_SLEEP;         // [RQ7]
                     next_s.tout    = TIMEOUT_SLEEP;           // [RQ8]
                     next_s.wdg     = WDG_CLR;                 // [RQ8]
                     next_s.pre     = PRE_CLR;                 // [RQ8]
                     next_s.wdg_clr = 1'b1;
                     next_s.osc     = 1'b0;                    // [RQ9]
                     next_s.sleep   = 1'b1;                    // [RQ9]
                     next_s.busy    = 1'b1;
                     next_s.st      = ST_SLEEP;
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_RET2: begin
            // Second cycle: return address lands, no status write
            next_s.pc_load = 1'b1;                             // [RQ2]
            next_s.busy    = 1'b0;
            next_s.done    = 1'b1;
            next_s.st      = ST_IDLE;
         end
         ST_SLEEP: begin
            // Wake handling belongs elsewhere; here only restart the clock, clear sleep and busy, pulse done, and return to idle
            if (wake_i) begin
               next_s.osc   = 1'b1;
               next_s.sleep = 1'b0;
               next_s.busy  = 1'b0;
               next_s.done  = 1'b1;
               next_s.st    = ST_IDLE;
            end
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s.st      <= ST_IDLE;
         s.busy    <= 1'b0;
         s.done    <= 1'b0;
         s.pop     <= 1'b0;
         s.pc_load <= 1'b0;
         s.ra      <= RA_RST;
         s.f_we    <= 1'b0;
         s.f_addr  <= '0;
         s.f_data  <= '0;
         s.w_we    <= 1'b0;
         s.w_data  <= '0;
         s.c_we    <= 1'b0;
         s.c       <= 1'b0;
         s.tout    <= TIMEOUT_RST;
         s.pdwn    <= POWERDOWN_RST;
         s.wdg_clr <= 1'b0;
         s.wdg     <= WDG_CLR;
         s.pre     <= PRE_CLR;
         s.osc     <= OSC_RST;
         s.sleep   <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign busy_o                  = s.busy;
   assign done_o                  = s.done;
   assign stack_pop_o             = s.pop;
   assign pc_load_o               = s.pc_load;
   assign program_counter_o       = s.ra;
   assign file_we_o               = s.f_we;
   assign file_waddr_o            = s.f_addr;
   assign file_wdata_o            = s.f_data;
   assign w_we_o                  = s.w_we;
   assign w_wdata_o               = s.w_data;
   assign carry_we_o              = s.c_we;
   assign carry_o                 = s.c;
   assign timeout_status_flag_o   = s.tout;
   assign powerdown_status_flag_o = s.pdwn;
   assign watchdog_clear_o        = s.wdg_clr;
   assign watchdog_counter_o      = s.wdg;
   assign prescaler_o             = s.pre;
   assign osc_run_o               = s.osc;
   assign sleeping_o              = s.sleep;
endmodule : rotate_return_sleep_exec

// [rrs_sva.sv]
`timescale 1ns/1ps
module rrs_sva
   import rotate_return_sleep_pkg::*;
(
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   input wire logic              issue_i,
   input wire op_e               op_i,
   input wire logic              dest_i,
   input wire logic [DATA_W-1:0] file_data_i,
   input wire logic              carry_i,
   input wire logic [RA_W-1:0]   stack_top_entry_i,
   input wire logic              busy_o,
   input wire logic              done_o,
   input wire logic              stack_pop_o,
   input wire logic              pc_load_o,
   input wire logic [RA_W-1:0]   program_counter_o,
   input wire logic              file_we_o,
   input wire logic              w_we_o,
   input wire logic [DATA_W-1:0] w_wdata_o,
   input wire logic              carry_o,
   input wire logic              timeout_status_flag_o,
   input wire logic              powerdown_status_flag_o,
   input wire logic [WDG_W-1:0]  watchdog_counter_o,
   input wire logic              osc_run_o,
   input wire logic              sleeping_o
);
   // ==========================================
   // Checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic take = issue_i && !busy_o;
   AST_RET_POP: assert property (take && op_i == OP_RETURN |=> stack_pop_o &&
      program_counter_o == $past(stack_top_entry_i)) else $error("return pop wrong");
   AST_RET_TWO: assert property (take && op_i == OP_RETURN |=> busy_o && !done_o
      ##1 pc_load_o && done_o && !busy_o) else $error("return length wrong");
   AST_RL_VAL: assert property (take && op_i == OP_ROT_LEFT && !dest_i |=>
      {carry_o, w_wdata_o} == {$past(file_data_i), $past(carry_i)}) else $error("rl wrong");
   AST_RL_DEST: assert property (take && op_i == OP_ROT_LEFT |=>
      file_we_o == $past(dest_i) && w_we_o != $past(dest_i)) else $error("rl dest wrong");
   AST_RR_VAL: assert property (take && op_i == OP_ROT_RIGHT && !dest_i |=>
      {w_wdata_o, carry_o} == {$past(carry_i), $past(file_data_i)}) else $error("rr wrong");
   AST_RR_DEST: assert property (take && op_i == OP_ROT_RIGHT |=>
      file_we_o == $past(dest_i) && w_we_o != $past(dest_i)) else $error("rr dest wrong");
   AST_SLP_FLAG: assert property (take && op_i == OP_SLEEP |=>
      !powerdown_status_flag_o && timeout_status_flag_o &&
      watchdog_counter_o == '0) else $error("sleep flags wrong");
   AST_SLP_OSC: assert property (take && op_i == OP_SLEEP |=>
      !osc_run_o && sleeping_o && busy_o) else $error("sleep entry wrong");
endmodule : rrs_sva
bind rotate_return_sleep_exec rrs_sva rrs_sva_inst (.*);

// [tb.sv]
`timescale 1ns/1ps
module tb
   import rotate_return_sleep_pkg::*;
;
   logic clk_i, rst_n_i, issue_i, dest_i, carry_i, wake_i, busy_o, done_o, stack_pop_o;
   logic pc_load_o, file_we_o, w_we_o, carry_we_o, carry_o, watchdog_clear_o, osc_run_o;
   logic timeout_status_flag_o, powerdown_status_flag_o, sleeping_o;
   op_e                op_i;
   logic [RA_W-1:0]    stack_top_entry_i, program_counter_o, ret_addr;
   logic [ADDR_W-1:0]  file_addr_i, file_waddr_o;
   logic [DATA_W-1:0]  file_data_i, file_wdata_o, w_wdata_o;
   logic [WDG_W-1:0]   watchdog_counter_o;
   logic [PRE_W-1:0]   prescaler_o;
   int unsigned        mismatches, total_checks;
   logic [31:0]        seed = 32'h0001_1600;
   logic [8:0]         ex;
   rotate_return_sleep_exec rotate_return_sleep_exec_inst (.*);
   // ==========================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction : xs
   // {carry, result}
   function automatic logic [8:0] rot(input logic [7:0] v, input logic c, input logic l);
      return l ? {v, c} : {v[0], c, v[7:1]};
   endfunction : rot
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Run needs about 95 cycles
   initial begin
      #4000;
      mismatches++;
      complete_run();
   end
   // ==========================================
   // Tests
   initial begin
      {rst_n_i, issue_i, dest_i, carry_i, wake_i, file_addr_i, file_data_i} = '0;
      op_i = OP_NONE;
      stack_top_entry_i = '0;
      repeat (20) @(negedge clk_i);
      rst_n_i = 1'b1;
      // Back to back, all-zero and all-one operands first
      for (int i = 0; i < 60; i++) begin
         seed = xs(seed);
         issue_i = 1'b1;
         op_i = seed[0] ? OP_ROT_LEFT : OP_ROT_RIGHT;
         {dest_i, carry_i, file_addr_i, file_data_i} = seed[24:8];
         if (i < 4) file_data_i = {8{i[1]}};
         ex = rot(file_data_i, carry_i, op_i == OP_ROT_LEFT);
         @(posedge clk_i);
         #1;
         chk({file_we_o, w_we_o, carry_we_o, done_o, timeout_status_flag_o,
              powerdown_status_flag_o}, {dest_i, !dest_i, 4'hf});
         chk({carry_o, dest_i ? file_wdata_o : w_wdata_o}, ex);
         if (dest_i) chk(file_waddr_o, file_addr_i);
         @(negedge clk_i);
      end
      $display("rotate test finished");
      // Issue held through the busy cycle must be refused
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         op_i = OP_RETURN;
         stack_top_entry_i = (i == 0) ? '1 : seed[12:0];
         ret_addr = stack_top_entry_i;
         @(posedge clk_i);
         #1;
         chk({stack_pop_o, busy_o, program_counter_o}, {2'b11, ret_addr});
         @(negedge clk_i);
         stack_top_entry_i = ~ret_addr;
         @(posedge clk_i);
         #1;
         chk({pc_load_o, done_o, busy_o, stack_pop_o, carry_we_o, program_counter_o},
             {5'h18, ret_addr});
         @(negedge clk_i);
      end
      $display("return test finished");
      op_i = OP_SLEEP;
      @(posedge clk_i);
      #1;
      chk({powerdown_status_flag_o, timeout_status_flag_o, watchdog_clear_o,
           watchdog_counter_o, prescaler_o, osc_run_o, sleeping_o},
          {3'b011, 16'h0, 2'b01});
      // A rotate offered while asleep must not run
      @(negedge clk_i);
      op_i = OP_ROT_LEFT;
      repeat (5) @(negedge clk_i);
      chk({osc_run_o, sleeping_o, busy_o, file_we_o, w_we_o, carry_we_o, done_o},
          7'h30);
      issue_i = 1'b0;
      wake_i = 1'b1;
      @(posedge clk_i);
      #1;
      chk({osc_run_o, sleeping_o, busy_o, done_o}, 4'h9);
      @(negedge clk_i);
      wake_i = 1'b0;
      $display("sleep test finished");
      complete_run();
   end
endmodule : tb
